//--- src/srp_port_ctrl.sv
// Command and data port logic of a burst-of-two double-data-rate static memory.
// Assumes K and K_N come from pins, run well below half of CORE_CLK and are sampled.
//
// Function
// R1 - Either input clock static over 30 ns resets the delay loop for relock.
// R2 - After a loop reset a stable clock is needed for the lock period.
// R3 - A low-to-high edge on the loop-disable pin resets the delay loop.
// R4 - The controller resets the loop whenever the clock frequency changes.
// R5 - Disable pin raised before a stable clock needs a later loop reset.
// R6 - Second burst address is the registered address plus one.
// R7 - Read and write sequencers run independently, both may act together.
// R8 - All sequencer steps happen on the primary clock rising edge; here the pending write clears and the array write lands at the K_N rise.
// R9 - Read at edge t gives words at t+2.5 and t+3.0.
// R10 - Write at edge t takes words at t and t+0.5.
// R11 - The controller spaces reads and writes two primary edges apart.
// R12 - A same-type command on the very next primary edge is discarded.
// R13 - Both selects low after a no-operation cycle: read done, write dropped.
// R14 - The controller finishes all transfers before stopping the clocks.
// R15 - Byte-masked writes need the write select low at edge t.
// R16 - Byte enable low writes its nine bits; all high aborts the beat.
// R17 - Both selects high is no operation with outputs in high impedance.
// R18 - With clocks stopped all data states hold their previous values.
// R19 - Lock is reached within 2048 stable primary clock cycles.
// R20 - Disable pin low bypasses the loop with one cycle read latency.
`timescale 1ns/10ps
`include "srp_map.svh"

module srp_port_ctrl
  import srp_pkg::*;
#(
  parameter int BYTES     = `SRP_BYTES,
  parameter int ADDR_W    = `SRP_ADDR_W,
  parameter int LOCK_KCYC = `SRP_LOCK_KCYC
) (
  input  wire logic                             CORE_CLK,
  input  wire logic                             SRST,
  input  wire logic                             CE,
  input  wire logic                             K,
  input  wire logic                             K_N,
  input  wire logic                             READ_SEL_N,
  input  wire logic                             WRITE_SEL_N,
  input  wire logic                             DLL_DISABLE_N,
  input  wire logic [ADDR_W-1:0]                RD_ADDR,
  input  wire logic [ADDR_W-1:0]                WR_ADDR,
  input  wire logic [BYTES*`SRP_LANE_W-1:0]     D,
  input  wire logic [BYTES-1:0]                 BYTE_WRITE_ENABLE_N,
  output logic      [BYTES*`SRP_LANE_W-1:0]     Q,
  output logic                                  Q_OE,
  output logic                                  DLL_READY
);

  localparam int DW       = BYTES * `SRP_LANE_W;
  localparam int LW       = `SRP_LANE_W;
  localparam int STOP_LIM = `SRP_STOP_CYC + 1;

  // -----------------------------------------------------------------
  // Parameter checks.
  // -----------------------------------------------------------------
  if (BYTES < 1 || ADDR_W < 2 || LOCK_KCYC < 1 || LOCK_KCYC > `SRP_LOCK_MAX) begin : g_bad
    $error("Unsupported parameter value for the port control block.");
  end

  // -----------------------------------------------------------------
  // State record.
  // -----------------------------------------------------------------
  typedef struct packed {
    logic [2:0]                  k_sync;
    logic [2:0]                  kn_sync;
    logic [2:0]                  doff_sync;
    logic [1:0]                  rn_s;
    logic [1:0]                  wn_s;
    logic [1:0][ADDR_W-1:0]      ra_s;
    logic [1:0][ADDR_W-1:0]      wa_s;
    logic [1:0][DW-1:0]          d_s;
    logic [1:0][BYTES-1:0]       be_s;
    logic [`SRP_STALL_W-1:0]     stall_k;
    logic [`SRP_STALL_W-1:0]     stall_kn;
    srp_dll_e                    dll;
    logic [`SRP_LOCK_W-1:0]      lock_cnt;
    logic                        rdy;
    logic                        prev_nop;
    logic                        rd_last;
    logic                        wr_last;
    logic [2:0]                  rd_v;
    logic [2:0][ADDR_W-1:0]      rd_a;
    logic                        wr_pend;
    logic [DW-1:0]               wr_d0;
    logic [BYTES-1:0]            wr_be0;
    logic [DW-1:0]               q;
    logic                        q_oe;
  } srp_state_s;

  srp_state_s  r;
  srp_state_s  next_r;
  logic [DW-1:0] mem [0:(2**ADDR_W)-1];

  logic              k_rise;
  logic              kn_rise;
  logic              doff_rise;
  logic              doff;
  logic              bypass;
  logic              ready;
  logic              stopped;
  logic              rn;
  logic              wn;
  logic              rd_acc;
  logic              wr_acc;
  logic              mem_we;
  logic [ADDR_W-1:0] wa;
  logic [ADDR_W-1:0] wa_p1;
  logic [DW-1:0]     m0;
  logic [DW-1:0]     m1;

  // -----------------------------------------------------------------
  // Edge and command decode.
  // -----------------------------------------------------------------
  // Edges are taken from the second and third sync stages only.
  assign k_rise    = r.k_sync[1] & ~r.k_sync[2];      // see R8
  assign kn_rise   = r.kn_sync[1] & ~r.kn_sync[2];
  assign doff      = r.doff_sync[1];
  assign doff_rise = r.doff_sync[1] & ~r.doff_sync[2];
  assign bypass    = (r.dll == SRP_BYPASS);
  assign ready     = (r.dll != SRP_LOCKING);
  assign stopped   = (r.stall_k == STOP_LIM[`SRP_STALL_W-1:0]) ||
                     (r.stall_kn == STOP_LIM[`SRP_STALL_W-1:0]);   // see R1
  assign rn        = r.rn_s[1];
  assign wn        = r.wn_s[1];
  // A same-type command right after an accepted one is dropped.
  assign rd_acc    = k_rise & ready & ~rn & ~r.rd_last;             // see R12 see R11
  // The write loses only when both arrive after an idle edge.
  assign wr_acc    = k_rise & ready & ~wn & ~r.wr_last &
                     ~(r.prev_nop & rd_acc);                       // see R13 see R7 see R15

  // Write port: both beats land at the K_N edge, once the address is known.
  assign mem_we = CE & kn_rise & r.wr_pend;                        // see R10
  assign wa     = r.wa_s[1];
  assign wa_p1  = wa + 1'b1;                                       // see R6

  // Per-lane bit masks; an enable held high leaves its nine bits alone.
  for (genvar g = 0; g < BYTES; g++) begin : g_lane
    assign m0[g*LW +: LW] = {LW{~r.wr_be0[g]}};                    // see R16
    assign m1[g*LW +: LW] = {LW{~r.be_s[1][g]}};
  end

  // -----------------------------------------------------------------
  // Next-state logic.
  // -----------------------------------------------------------------
  // All pins pass two flops; data and controls stay aligned with the clocks.
  always_comb begin
    next_r           = r;
    next_r.k_sync    = {r.k_sync[1:0], K};
    next_r.kn_sync   = {r.kn_sync[1:0], K_N};
    next_r.doff_sync = {r.doff_sync[1:0], DLL_DISABLE_N};
    next_r.rn_s      = {r.rn_s[0], READ_SEL_N};
    next_r.wn_s      = {r.wn_s[0], WRITE_SEL_N};
    next_r.ra_s      = {r.ra_s[0], RD_ADDR};
    next_r.wa_s      = {r.wa_s[0], WR_ADDR};
    next_r.d_s       = {r.d_s[0], D};
    next_r.be_s      = {r.be_s[0], BYTE_WRITE_ENABLE_N};

    // Static-clock timers saturate so a long stop keeps the loop in reset.
    if (r.k_sync[1] != r.k_sync[2]) begin
      next_r.stall_k = '0;
    end else if (r.stall_k != STOP_LIM[`SRP_STALL_W-1:0]) begin
      next_r.stall_k = r.stall_k + 1'b1;
    end
    if (r.kn_sync[1] != r.kn_sync[2]) begin
      next_r.stall_kn = '0;
    end else if (r.stall_kn != STOP_LIM[`SRP_STALL_W-1:0]) begin
      next_r.stall_kn = r.stall_kn + 1'b1;
    end

    // Delay-loop sequencing.
    if (!doff) begin
      next_r.dll      = SRP_BYPASS;                                // see R20
      next_r.lock_cnt = '0;
    end else if (doff_rise || stopped) begin
      next_r.dll      = SRP_LOCKING;                               // see R1 see R3
      next_r.lock_cnt = '0;
    end else begin
      unique case (r.dll)
        SRP_LOCKING: begin
          if (k_rise) begin
            if (r.lock_cnt == `SRP_LOCK_W'(LOCK_KCYC - 1)) begin
              next_r.dll = SRP_LOCKED;                             // see R19 see R2
            end else begin
              next_r.lock_cnt = r.lock_cnt + 1'b1;
            end
          end
        end
        SRP_LOCKED: begin
          next_r.dll = SRP_LOCKED;
        end
        SRP_BYPASS: begin
          next_r.dll = SRP_LOCKING;
        end
      endcase
    end
    next_r.rdy = (next_r.dll != SRP_LOCKING);

    // Command sequencing, stepped by the primary rising edge; the pending write clears at the K_N rise.
    if (k_rise) begin
      next_r.prev_nop = rn & wn;
      next_r.rd_last  = rd_acc;
      next_r.wr_last  = wr_acc;
      next_r.rd_v     = {r.rd_v[1:0], rd_acc};                     // see R9
      next_r.rd_a     = {r.rd_a[1:0], r.ra_s[1]};
      if (wr_acc) begin
        next_r.wr_pend = 1'b1;
        next_r.wr_d0   = r.d_s[1];
        next_r.wr_be0  = r.be_s[1];
      end
    end else if (kn_rise && r.wr_pend) begin
      next_r.wr_pend = 1'b0;
    end

    // Output beats; with nothing due the outputs float.
    if (k_rise) begin
      if (!bypass && r.rd_v[`SRP_DLL_STAGE]) begin
        next_r.q    = mem[r.rd_a[`SRP_DLL_STAGE] + 1'b1];          // see R9 see R6
        next_r.q_oe = 1'b1;
      end else if (bypass && r.rd_v[`SRP_BYP_STAGE]) begin
        next_r.q    = mem[r.rd_a[`SRP_BYP_STAGE]];                 // see R20
        next_r.q_oe = 1'b1;
      end else begin
        next_r.q_oe = 1'b0;                                        // see R17
      end
    end else if (kn_rise) begin
      if (!bypass && r.rd_v[`SRP_DLL_STAGE]) begin
        next_r.q    = mem[r.rd_a[`SRP_DLL_STAGE]];
        next_r.q_oe = 1'b1;
      end else if (bypass && r.rd_v[`SRP_BYP_STAGE2]) begin
        next_r.q    = mem[r.rd_a[`SRP_BYP_STAGE2] + 1'b1];
        next_r.q_oe = 1'b1;
      end else begin
        next_r.q_oe = 1'b0;
      end
    end
  end

  // -----------------------------------------------------------------
  // State registers.
  // -----------------------------------------------------------------
  // No edge means no change, so a stopped clock freezes the data path; only the input sync stages, the static-clock timers and the delay loop move.
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      // The clock and disable sync stages start at their pins' idle levels, so no false edge follows reset.
      r           <= '0;
      r.dll       <= SRP_LOCKING;
      r.kn_sync   <= '1;
      r.doff_sync <= '1;
    end else if (CE) begin
      r <= next_r;                                                 // see R18
    end
  end

  // The array itself is not reset; its contents are unknown after power-up.
  always_ff @(posedge CORE_CLK) begin
    if (mem_we) begin
      mem[wa]    <= (mem[wa] & ~m0) | (r.wr_d0 & m0);              // see R16
      mem[wa_p1] <= (mem[wa_p1] & ~m1) | (r.d_s[1] & m1);
    end
  end

  assign Q         = r.q;
  assign Q_OE      = r.q_oe;
  assign DLL_READY = r.rdy;

  // -----------------------------------------------------------------
  // Checks.
  // -----------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (SRST);

  stop_reset_a: assert property (CE && doff && stopped |=>   // see R1
    r.dll == SRP_LOCKING && r.lock_cnt == '0)
    else $error("Static clock did not reset the delay loop.");

  doff_relock_a: assert property (CE && doff_rise |=> r.dll == SRP_LOCKING && !DLL_READY) // see R3
    else $error("Disable pin rise did not reset the delay loop.");

  lock_time_a: assert property (CE && doff && !stopped && k_rise &&   // see R19
    r.dll == SRP_LOCKING && r.lock_cnt == `SRP_LOCK_W'(LOCK_KCYC - 1) |=> DLL_READY)
    else $error("Lock not reached after the lock period.");

  bypass_mode_a: assert property (CE && !doff |=> r.dll == SRP_BYPASS && DLL_READY) // see R20
    else $error("Disable pin low did not bypass the loop.");

  read_discard_a: assert property (CE && k_rise && !rn && r.rd_last |=> !r.rd_v[0]) // see R12
    else $error("Back-to-back read was not discarded.");

  read_wins_a: assert property (CE && k_rise && ready && !rn && !wn && r.prev_nop &&  // see R13
    !r.rd_last |=> r.rd_v[0] && (r.wr_pend == $past(r.wr_pend)))
    else $error("Write not dropped against read after idle.");

  both_ports_a: assert property (CE && k_rise && ready && !rn && !wn && !r.prev_nop && // see R7
    !r.rd_last && !r.wr_last |=> r.rd_v[0] && r.wr_pend)
    else $error("Read and write did not start together.");

  nop_float_a: assert property (CE && k_rise && r.rd_v == '0 |=> !Q_OE) // see R17
    else $error("Outputs driven with no read due.");

  second_word_a: assert property (CE && k_rise && !bypass && r.rd_v[2] |=>  // see R9
    Q_OE && Q == mem[$past(r.rd_a[2]) + 1'b1])
    else $error("Second read word is not from the next address.");

  frozen_a: assert property (!CE || (!k_rise && !kn_rise) |=> $stable(Q) && $stable(Q_OE)) // see R18
    else $error("Outputs changed without a clock edge.");

endmodule

//--- src/srp_map.svh
// Named offsets, widths and timing counts for the burst-of-two port control block.
// Assumes it is included by bare name from the design module.
`ifndef SRP_MAP_SVH
`define SRP_MAP_SVH

// Core clock period and the static-clock time that resets the delay loop.
`define SRP_CLK_PERIOD_NS 5
`define SRP_STOP_NS       30
`define SRP_STOP_CYC      ((`SRP_STOP_NS + `SRP_CLK_PERIOD_NS - 1) / `SRP_CLK_PERIOD_NS)
`define SRP_STALL_W       4

// Lock period in primary clock cycles, and the width of its counter.
`define SRP_LOCK_KCYC     2048
`define SRP_LOCK_W        12
`define SRP_LOCK_MAX      4096

// Data lane layout and default array size.
`define SRP_LANE_W        9
`define SRP_BYTES         4
`define SRP_ADDR_W        8

// Read pipeline stage that holds the read due on the output.
`define SRP_DLL_STAGE     2
`define SRP_BYP_STAGE     0
`define SRP_BYP_STAGE2    1

`endif

//--- src/srp_pkg.sv
// Types shared by the burst-of-two port control block.
// Assumes the constant header is on the include path.
package srp_pkg;

  // -----------------------------------------------------------------
  // Delay-loop state, one-hot.
  // -----------------------------------------------------------------
  typedef enum logic [2:0] {
    SRP_LOCKING = 3'b001,
    SRP_LOCKED  = 3'b010,
    SRP_BYPASS  = 3'b100
  } srp_dll_e;

endpackage

//--- tb/srp_host_model.sv
// Behavioural memory controller driving the pin side of the burst-of-two port block.
// Assumes a free-running core clock; K and K_N are made from it at four core cycles a phase.
`timescale 1ns/10ps

module srp_host_model (
  input  wire logic        CORE_CLK,
  input  wire logic [35:0] Q,
  input  wire logic        Q_OE,
  output logic             K,
  output logic             K_N,
  output logic             READ_SEL_N,
  output logic             WRITE_SEL_N,
  output logic [7:0]       RD_ADDR,
  output logic [7:0]       WR_ADDR,
  output logic [35:0]      D,
  output logic [3:0]       BYTE_WRITE_ENABLE_N
);
  // ---------------------------------------------------------------
  // Idle levels
  // ---------------------------------------------------------------
  // The clocks rest with K low between periods, so a pause is a clock stop.
  initial begin
    K                   = 1'b0;
    K_N                 = 1'b1;
    READ_SEL_N          = 1'b1;
    WRITE_SEL_N         = 1'b1;
    RD_ADDR             = 8'h00;
    WR_ADDR             = 8'h00;
    D                   = 36'h0;
    BYTE_WRITE_ENABLE_N = 4'hf;
  end

  // ---------------------------------------------------------------
  // One K period of eight core cycles
  // ---------------------------------------------------------------
  // Beat 0 rides the K rise, beat 1 and the write address the K_N rise.
  // Q is sampled mid-phase, well clear of the design's update edges.
  // Lines that carry nothing keep toggling so stale values never pass.
  task automatic kcycle(input logic rd, input logic wr, input logic [7:0] ra,
                        input logic [7:0] wa, input logic [35:0] d0, input logic [35:0] d1,
                        input logic [3:0] b0, input logic [3:0] b1,
                        output logic [35:0] qn, output logic [35:0] qk,
                        output logic on, output logic ok);
    @(posedge CORE_CLK);
    READ_SEL_N          <= ~rd;
    WRITE_SEL_N         <= ~wr;
    RD_ADDR             <= rd ? ra : ~RD_ADDR;
    D                   <= wr ? d0 : ~D;
    BYTE_WRITE_ENABLE_N <= b0;
    repeat (2) @(posedge CORE_CLK);
    K   <= 1'b1;
    K_N <= 1'b0;
    @(posedge CORE_CLK);
    @(negedge CORE_CLK);
    qn = Q;
    on = Q_OE;
    @(posedge CORE_CLK);
    WR_ADDR             <= wr ? wa : ~WR_ADDR;
    D                   <= wr ? d1 : ~D;
    BYTE_WRITE_ENABLE_N <= b1;
    repeat (2) @(posedge CORE_CLK);
    K   <= 1'b0;
    K_N <= 1'b1;
    @(posedge CORE_CLK);
    @(negedge CORE_CLK);
    qk = Q;
    ok = Q_OE;
  endtask
endmodule

//--- tb/srp_port_ctrl_tb.sv
// Self-checking bench for the burst-of-two port block with a reference array.
// Assumes the host model above and a short lock count for simulation.
`timescale 1ns/10ps

module srp_port_ctrl_tb;
  localparam int LK = 8;
  logic        CORE_CLK, SRST, CE, DLL_DISABLE_N, K, K_N, READ_SEL_N, WRITE_SEL_N;
  logic        Q_OE, DLL_READY;
  logic [7:0]  RD_ADDR, WR_ADDR, ra_h [4];
  logic [35:0] D, Q, exp_qn, q0, mem [256];
  logic [3:0]  BYTE_WRITE_ENABLE_N;
  logic        rv_h [4];
  logic        exp_on, wr_prev, prev_nop, byp, lk;
  int          n_fail, checked;
  int unsigned seed;

  srp_port_ctrl #(.BYTES(4), .ADDR_W(8), .LOCK_KCYC(LK)) i_srp_port_ctrl (
    .CORE_CLK(CORE_CLK), .SRST(SRST), .CE(CE), .K(K), .K_N(K_N), .READ_SEL_N(READ_SEL_N),
    .WRITE_SEL_N(WRITE_SEL_N), .DLL_DISABLE_N(DLL_DISABLE_N), .RD_ADDR(RD_ADDR),
    .WR_ADDR(WR_ADDR), .D(D), .BYTE_WRITE_ENABLE_N(BYTE_WRITE_ENABLE_N), .Q(Q),
    .Q_OE(Q_OE), .DLL_READY(DLL_READY));
  srp_host_model i_srp_host_model (
    .CORE_CLK(CORE_CLK), .Q(Q), .Q_OE(Q_OE), .K(K), .K_N(K_N), .READ_SEL_N(READ_SEL_N),
    .WRITE_SEL_N(WRITE_SEL_N), .RD_ADDR(RD_ADDR), .WR_ADDR(WR_ADDR), .D(D),
    .BYTE_WRITE_ENABLE_N(BYTE_WRITE_ENABLE_N));

  // ---------------------------------------------------------------
  // Clock and helpers
  // ---------------------------------------------------------------
  // Core clock at 200 MHz.
  initial begin
    CORE_CLK = 1'b0;
    forever #2.5 CORE_CLK = ~CORE_CLK;
  end

  // Lanes whose enable is low take the new nine bits.
  function automatic logic [35:0] merge(input logic [35:0] old, input logic [35:0] d,
                                        input logic [3:0] be);
    merge = old;
    for (int i = 0; i < 4; i++) if (!be[i]) merge[9*i +: 9] = d[9*i +: 9];
  endfunction

  function automatic logic [35:0] rw();
    logic [63:0] r;
    r = {$urandom, $urandom};
    return r[35:0];
  endfunction

  task automatic check(input string name, input logic [35:0] seen, input logic [35:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // One K period with its expectations
  // ---------------------------------------------------------------
  // An output at an edge sees writes of earlier periods only, since a write
  // lands at the same K_N event that may carry read data.
  task automatic step(input logic rd, input logic wr, input logic [7:0] ra, input logic [7:0] wa,
                      input logic [35:0] d0, input logic [35:0] d1, input logic [3:0] b0,
                      input logic [3:0] b1);
    logic [35:0] qn, qk;
    logic        on, ok, ek, racc, wacc;
    logic [7:0]  ak;
    i_srp_host_model.kcycle(rd, wr, ra, wa, d0, d1, b0, b1, qn, qk, on, ok);
    for (int i = 3; i > 0; i--) begin
      rv_h[i] = rv_h[i-1];
      ra_h[i] = ra_h[i-1];
    end
    check("q_oe_kn", 36'(on), 36'(exp_on));
    if (exp_on) check("q_kn", qn, exp_qn);
    ek = byp ? rv_h[1] : rv_h[3];
    ak = byp ? ra_h[1] : ra_h[3] + 8'h01;
    check("q_oe_k", 36'(ok), 36'(ek));
    if (ek) check("q_k", qk, mem[ak]);
    if (lk) check("dll_ready", 36'(DLL_READY), 36'h1);
    racc    = rd && !rv_h[1];
    wacc    = wr && !wr_prev && !(rd && prev_nop);
    rv_h[0] = racc;
    ra_h[0] = ra;
    exp_on  = byp ? rv_h[1] : rv_h[2];
    exp_qn  = byp ? mem[ra_h[1] + 8'h01] : mem[ra_h[2]];
    if (wacc) begin
      mem[wa]         = merge(mem[wa], d0, b0);
      mem[wa + 8'h01] = merge(mem[wa + 8'h01], d1, b1);
    end
    wr_prev  = wacc;
    prev_nop = !rd && !wr;
  endtask

  task automatic idle(input int n);
    repeat (n) step(1'b0, 1'b0, 8'h00, 8'h00, 36'h0, 36'h0, 4'hf, 4'hf);
  endtask

  task automatic rnd(input int n);
    repeat (n) step(1'($urandom), 1'($urandom), 8'($urandom), 8'($urandom), rw(), rw(),
                    ($urandom % 4 == 0) ? 4'hf : 4'($urandom), 4'($urandom));
  endtask

  // Idle periods until lock, bounded past the lock count.
  task automatic wait_lock();
    int n;
    n = 0;
    while (DLL_READY !== 1'b1 && n < LK + 8) begin
      idle(1);
      n++;
    end
    check("lock_time", 36'(n <= LK + 2), 36'h1);
    lk = 1'b1;
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    n_fail = 0; checked = 0; lk = 0; byp = 0; exp_on = 0; wr_prev = 0; prev_nop = 1;
    exp_qn = 36'h0;
    for (int i = 0; i < 4; i++) begin
      rv_h[i] = 1'b0;
      ra_h[i] = 8'h00;
    end
    SRST = 1'b1; CE = 1'b1; DLL_DISABLE_N = 1'b1;
    seed = $urandom(32'h780f486d);
    repeat (20) @(posedge CORE_CLK);
    SRST <= 1'b0;
    @(negedge CORE_CLK);
    check("ready_rst", 36'(DLL_READY), 36'h0);
    wait_lock();
    // Fill the whole array so every later read has a known answer.
    for (int i = 0; i < 128; i++) begin
      step(1'b0, 1'b1, 8'h00, 8'(2 * i), rw(), rw(), 4'h0, 4'h0);
      idle(1);
    end
    idle(1);
    step(1'b1, 1'b1, 8'hff, 8'h40, rw(), rw(), 4'h0, 4'h0);
    step(1'b1, 1'b1, 8'h20, 8'h50, rw(), rw(), 4'h0, 4'h0);
    rnd(300);
    idle(4);
    q0 = Q;
    lk = 1'b0;
    // Clocks stand still for 80 ns, well past the static limit.
    repeat (16) @(posedge CORE_CLK);
    @(negedge CORE_CLK);
    check("ready_stop", 36'(DLL_READY), 36'h0);
    check("q_hold", Q, q0);
    wait_lock();
    rnd(200);
    idle(4);
    lk = 1'b0;
    @(posedge CORE_CLK);
    DLL_DISABLE_N <= 1'b0;
    byp = 1'b1;
    idle(2);
    check("ready_bypass", 36'(DLL_READY), 36'h1);
    lk = 1'b1;
    rnd(200);
    idle(4);
    lk = 1'b0;
    @(posedge CORE_CLK);
    DLL_DISABLE_N <= 1'b1;
    byp = 1'b0;
    idle(1);
    check("ready_toggle", 36'(DLL_READY), 36'h0);
    wait_lock();
    // Freeze the core for two cycles after each batch; work in flight must resume intact.
    repeat (3) begin
      rnd(50);
      @(posedge CORE_CLK);
      CE <= 1'b0;
      repeat (2) @(posedge CORE_CLK);
      CE <= 1'b1;
    end
    stop_test();
  end

  // A hang counts as a mismatch.
  initial begin
    #200000;
    n_fail++;
    stop_test();
  end
endmodule
